// ===== design/clock_ctrl_pkg.sv
// Constants, field layouts and carrier types of the system clock controller.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package clock_ctrl_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
	localparam logic [7:0] OFS_OSC_STAT = 8'h04;
	localparam logic [7:0] OFS_CLK_CFG = 8'h08;
	localparam logic [7:0] OFS_GATE = 8'h0c;
	localparam logic [7:0] OFS_SEC = 8'h10;
	localparam logic [7:0] OFS_FLAG_CLR = 8'h14;
	localparam logic [7:0] OFS_TRIM = 8'h18;
	localparam logic [7:0] OFS_PLL = 8'h1c;
	localparam logic [7:0] OFS_KSEL = 8'h20;
	// System clock root codes
	localparam logic [1:0] SRC_MULTISPEED = 2'h0;
	localparam logic [1:0] SRC_INT_16M = 2'h1;
	localparam logic [1:0] SRC_EXT_FAST = 2'h2;
	localparam logic [1:0] SRC_PLL = 2'h3;
	// Multispeed ranges: 12 codes, code 6 is 4 MHz
	localparam logic [3:0] MS_RANGE_4M = 4'h6;
	localparam logic [3:0] MS_RANGE_MAX = 4'hb;
	// Prescaler codes are powers of two
	localparam logic [3:0] AHB_DIV_MAX = 4'h8;
	localparam logic [2:0] APB_DIV_MAX = 3'h4;
	localparam logic [6:0] SLOW_DIV_LAST = 7'h7f;
	// Ready bit positions; PD_PERIPH is the type-C gate bit
	localparam int RDY_EXT_FAST = 0;
	localparam int RDY_INT_16M = 1;
	localparam int RDY_MULTI = 2;
	localparam int RDY_PLL = 3;
	localparam int RDY_EXT_SLOW = 4;
	localparam int RDY_INT_SLOW = 5;
	localparam int RDY_INT_48M = 6;
	localparam int NUM_RDY = 7;
	localparam int PD_PERIPH = 0;
	// Field positions in the flag-clear and trim write words
	localparam int CLR_FAST_FAIL = 0;
	localparam int CLR_SLOW_FAIL = 1;
	localparam int CLR_RESET_FLAGS = 2;
	localparam int TRIM_SW_SYNC = 19;
	// Reset values
	localparam logic [16:0] OSC_CTRL_RST = 17'h00068;
	localparam logic [17:0] GATE_RST = 18'h30000;

	typedef struct packed {
		logic int_48m_en;
		logic slow_fail_en;
		logic fast_fail_en;
		logic auto_trim_en;
		logic int_slow_en;
		logic [1:0] ext_slow_drive;
		logic ext_slow_bypass;
		logic ext_slow_en;
		logic [3:0] multispeed_range;
		logic multispeed_en;
		logic int_16m_en;
		logic ext_fast_bypass;
		logic ext_fast_en;
	} osc_ctrl_type;

	typedef struct packed {
		logic [1:0] pll_src;
		logic slow_out_en;
		logic slow_out_sel;
		logic [2:0] gen_out_sel;
		logic [2:0] apb_ls_div;
		logic [2:0] apb_hs_div;
		logic [3:0] ahb_div;
		logic [1:0] sys_sel;
	} clk_cfg_type;

	typedef struct packed {
		logic [7:0] audio2_sel;
		logic [7:0] unused_sel;
	} pad_type;

	typedef enum logic [1:0] {
		SW_RUN = 2'b00,
		SW_WAIT = 2'b01,
		SW_GATE = 2'b11
	} switch_state_type;
endpackage

// ===== design/system_clock_controller.sv
// System clock controller: source selection, prescalers, gating, failure
// monitor, clock outputs, security filter and oscillator trim engines.
// Assumes oscillators report ready and failure as asynchronous levels and
// deliver pre-divided tick levels; actual clock muxing sits outside.
// Notes on behaviour
// - System root chosen from multispeed, 16 MHz RC, fast oscillator or PLL.
// - Fast oscillator enable offered; it may also feed the PLL.
// - Fast oscillator bypass bit selects an external clock over a crystal.
// - Multispeed has twelve range codes and a software trim value.
// - Multispeed auto trimmed from slow oscillator ticks when enabled.
// - PLL fed by fast oscillator, 16 MHz RC or multispeed; 110 MHz cap.
// - Three PLLs with three independent output enables each.
// - Kernel clock selects independent of the system root selection.
// - 48 MHz RC usable for USB, SD, RNG and the general clock pin.
// - Type-C kernel clock from the 16 MHz RC, only once it runs.
// - Slow oscillator has four drive settings and a bypass bit.
// - Internal slow RC ticks divided by 128 for a 250 Hz source.
// - Reset leaves the multispeed RC at 4 MHz as system root.
// - Fast oscillator failure forces 16 MHz RC root and flags an interrupt.
// - Slow oscillator failure detected and flagged as an interrupt.
// - Software can stop core, memory and individual peripheral clocks.
// - AHB and both APB prescalers programmable, limited to 110 MHz.
// - General pin carries one selected clock; slow pin slow RC or oscillator.
// - With security on, non-secure access to system settings is blocked.
// - Secure peripherals' gate bits are hidden from non-secure access.
// - 48 MHz RC trimmed from a chosen sync source, manual trim allowed.
//
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps

module trim_engine #(
	parameter int CW = 16,
	parameter logic [CW-1:0] TARGET = 16'd1465
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic auto_i,
	input wire logic sync_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic [7:0] load_val_i,
	output logic [7:0] trim_o
);
	logic [CW-1:0] cnt_q;
	logic [7:0] trim_q;
	wire logic slow = cnt_q < TARGET;
	wire logic fast = cnt_q > TARGET;
	wire logic step_up = auto_i & sync_i & slow & (trim_q != 8'hff);
	wire logic step_dn = auto_i & sync_i & fast & (trim_q != 8'h00);
	assign trim_o = trim_q;
	// Manual load overrides a step in the same cycle for quick lock
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q <= '0;
			trim_q <= 8'h80;
		end
		else
		begin
			cnt_q <= sync_i ? '0 : cnt_q + CW'(tick_i);
			if (load_i)
				trim_q <= load_val_i;
			else if (step_up)
				trim_q <= trim_q + 8'h01;
			else if (step_dn)
				trim_q <= trim_q - 8'h01;
		end
	end
endmodule // trim_engine

module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);
	logic [W-1:0] s1_q, s2_q, s3_q, f_q;
	// Take the new level only when stages two and three agree
	wire logic [W-1:0] f_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
	assign level_o = f_q;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			f_q <= '0;
		end
		else
		begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
		end
	end
endmodule // pin_sync

module system_clock_controller #(
	parameter int PERIPHS = 16,
	parameter logic [15:0] MS_TRIM_TARGET = 16'd1465,
	parameter logic [15:0] T48_TRIM_TARGET = 16'd48000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_secure_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Security option and oscillator status (asynchronous)
	input wire logic security_enable_option_i,
	input wire logic [6:0] osc_ready_i,
	input wire logic ext_fast_fail_i,
	input wire logic ext_slow_fail_i,
	// Sync and tick sources (asynchronous levels)
	input wire logic usb_sof_i,
	input wire logic ext_slow_tick_i,
	input wire logic trim_sync_input_i,
	input wire logic int_slow_tick_i,
	input wire logic multispeed_tick_i,
	input wire logic int_48m_tick_i,
	// Oscillator and clock tree control
	output clock_ctrl_pkg::osc_ctrl_type osc_ctrl_o,
	output clock_ctrl_pkg::clk_cfg_type clk_cfg_o,
	output logic [1:0] sys_root_sel_o,
	output logic sys_root_gate_o,
	output logic [11:0] pll_ctrl_o,
	output logic [7:0] kernel_sel_o,
	output logic [7:0] multispeed_trim_o,
	output logic [7:0] int_48m_trim_o,
	// Gating
	output logic core_clk_en_o,
	output logic mem_clk_en_o,
	output logic [PERIPHS-1:0] periph_clk_en_o,
	output logic typec_pd_clk_en_o,
	// Clock outputs and events
	output logic [2:0] general_clock_out_sel_o,
	output logic slow_clock_out_en_o,
	output logic slow_clock_out_sel_o,
	output logic slow_250hz_tick_o,
	output logic fast_fail_irq_o,
	output logic slow_fail_irq_o,
	output logic reset_flag_clear_o
);
	import clock_ctrl_pkg::*;

	osc_ctrl_type osc_q, osc_d;
	clk_cfg_type cfg_q, cfg_d;
	switch_state_type st_q, st_d;
	logic [1:0] act_q;
	logic [17:0] gate_q;
	logic [PERIPHS-1:0] psec_q;
	logic [11:0] pll_q;
	logic [7:0] ksel_q;
	logic [3:0] tsel_q;
	logic ack_q, ffail_q, sfail_q, rflag_q, tick_pr_q;
	logic [31:0] rdat_q;
	logic [6:0] div_q;
	logic [14:0] sync_prev_q;
	logic [14:0] sync_lv;

	pin_sync #(.W(15)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i({int_48m_tick_i, multispeed_tick_i, int_slow_tick_i, trim_sync_input_i,
			ext_slow_tick_i, usb_sof_i, ext_slow_fail_i, ext_fast_fail_i, osc_ready_i}),
		.level_o(sync_lv)
	);

	wire logic [6:0] rdy = sync_lv[6:0];
	wire logic [14:7] rise = sync_lv[14:7] & ~sync_prev_q[14:7];
	wire logic fast_fail_ev = rise[7] & osc_q.fast_fail_en;
	wire logic slow_fail_ev = rise[8] & osc_q.slow_fail_en;

	// Bus decode
	wire logic req = wb_cyc_i & wb_stb_i;
	wire logic wr_fire = req & ack_q & wb_we_i;
	// Secured system settings are invisible to non-secure masters
	wire logic ns_lock = security_enable_option_i & ~wb_secure_i;
	wire logic [31:0] be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire logic a_osc = wb_adr_i == OFS_OSC_CTRL;
	wire logic a_stat = wb_adr_i == OFS_OSC_STAT;
	wire logic a_cfg = wb_adr_i == OFS_CLK_CFG;
	wire logic a_gate = wb_adr_i == OFS_GATE;
	wire logic a_sec = wb_adr_i == OFS_SEC;
	wire logic a_clr = wb_adr_i == OFS_FLAG_CLR;
	wire logic a_trim = wb_adr_i == OFS_TRIM;
	wire logic a_pll = wb_adr_i == OFS_PLL;
	wire logic a_ksel = wb_adr_i == OFS_KSEL;
	wire logic sec_reg = a_osc | a_cfg | a_clr | a_trim | a_pll | a_ksel | a_sec;
	wire logic blocked = ns_lock & sec_reg;
	wire logic [17:0] gate_hide = ns_lock ? {2'b00, 16'(psec_q)} : 18'h00000;

	wire logic [31:0] stat_word = {21'h000000, rflag_q, sfail_q, ffail_q, 1'b0, rdy};
	wire logic [31:0] cfg_word = {10'h000, act_q, 1'b0, cfg_q};
	wire logic [31:0] trim_word = {12'h000, tsel_q, int_48m_trim_o, multispeed_trim_o};
	wire logic [31:0] cur_word =
		a_osc ? {15'h0000, osc_q} :
		a_stat ? stat_word :
		a_cfg ? cfg_word :
		a_gate ? {14'h0000, gate_q & ~gate_hide} :
		a_sec ? 32'(psec_q) :
		a_trim ? trim_word :
		a_pll ? {20'h00000, pll_q} :
		a_ksel ? {24'h000000, ksel_q} : 32'h00000000;
	wire logic [31:0] rd_word = blocked ? 32'h00000000 : cur_word;
	wire logic [31:0] wv = (cur_word & ~be_mask) | (wb_dat_i & be_mask);
	wire logic [31:0] wclr = wb_dat_i & be_mask;
	wire logic wr_ok = wr_fire & ~blocked;
	wire logic clr_fast = wr_ok & a_clr & wclr[CLR_FAST_FAIL];
	wire logic clr_slow = wr_ok & a_clr & wclr[CLR_SLOW_FAIL];
	wire logic clr_rflag = wr_ok & a_clr & wclr[CLR_RESET_FLAGS];
	wire logic trim_wr = wr_ok & a_trim;
	wire logic sw_sync = trim_wr & wclr[TRIM_SW_SYNC];

	// range codes above the last one are clamped
	wire logic [3:0] ms_rng = (wv[7:4] > MS_RANGE_MAX) ? MS_RANGE_MAX : wv[7:4];
	// prescaler codes clamped to their legal span
	wire logic [3:0] ahb_w = (wv[5:2] > AHB_DIV_MAX) ? AHB_DIV_MAX : wv[5:2];
	wire logic [2:0] hs_w = (wv[8:6] > APB_DIV_MAX) ? APB_DIV_MAX : wv[8:6];
	wire logic [2:0] ls_w = (wv[11:9] > APB_DIV_MAX) ? APB_DIV_MAX : wv[11:9];

	always_comb
	begin
		osc_d = osc_q;
		if (wr_ok & a_osc)
		begin
			// oscillator enables, bypass and drive bits
			osc_d = osc_ctrl_type'(wv[16:0]);
			osc_d.multispeed_range = ms_rng;
		end
		// failover keeps the 16 MHz RC running
		if (fast_fail_ev)
			osc_d.int_16m_en = 1'b1;
	end

	always_comb
	begin
		cfg_d = cfg_q;
		if (wr_ok & a_cfg)
		begin
			cfg_d = clk_cfg_type'(wv[18:0]);
			cfg_d.ahb_div = ahb_w;
			cfg_d.apb_hs_div = hs_w;
			cfg_d.apb_ls_div = ls_w;
			// PLL input code 3 is not a source
			if (wv[18:17] == 2'h3)
				cfg_d.pll_src = cfg_q.pll_src;
		end
		if (fast_fail_ev)
			cfg_d.sys_sel = SRC_INT_16M;
	end

	// ready bit of the requested root
	wire logic tgt_rdy =
		(cfg_q.sys_sel == SRC_MULTISPEED) ? rdy[RDY_MULTI] :
		(cfg_q.sys_sel == SRC_INT_16M) ? rdy[RDY_INT_16M] :
		(cfg_q.sys_sel == SRC_EXT_FAST) ? rdy[RDY_EXT_FAST] : rdy[RDY_PLL];

	always_comb
	begin
		case (st_q)
			SW_RUN: st_d = (cfg_q.sys_sel != act_q) ? SW_WAIT : SW_RUN;
			SW_WAIT: st_d = (cfg_q.sys_sel == act_q) ? SW_RUN : (tgt_rdy ? SW_GATE : SW_WAIT);
			SW_GATE: st_d = SW_RUN;
			default: st_d = SW_RUN;
		endcase
		if (fast_fail_ev)
			st_d = SW_RUN;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// multispeed RC at 4 MHz after reset
			osc_q <= osc_ctrl_type'(OSC_CTRL_RST);
			cfg_q <= '0;
			act_q <= SRC_MULTISPEED;
			st_q <= SW_RUN;
		end
		else
		begin
			osc_q <= osc_d;
			cfg_q <= cfg_d;
			st_q <= st_d;
			if (fast_fail_ev)
				act_q <= SRC_INT_16M;
			// otherwise root changes only from the gated state
			else if (st_q == SW_GATE)
				act_q <= cfg_q.sys_sel;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			gate_q <= GATE_RST;
			psec_q <= '0;
			pll_q <= 12'h000;
			ksel_q <= 8'h00;
			tsel_q <= 4'h0;
		end
		else
		begin
			// hidden bits keep their value on non-secure writes
			if (wr_fire & a_gate)
				gate_q <= (gate_q & gate_hide) | (wv[17:0] & ~gate_hide);
			if (wr_ok & a_sec)
				psec_q <= wv[PERIPHS-1:0];
			// three PLL enables and nine output enables
			if (wr_ok & a_pll)
				pll_q <= wv[11:0];
			if (wr_ok & a_ksel)
				ksel_q <= wv[7:0];
			if (trim_wr)
				tsel_q <= wv[19:16];
		end
	end

	// sync source: 0 USB frame, 1 slow oscillator, 2 pin, 3 software
	wire logic sync48 =
		(tsel_q[1:0] == 2'h0) ? rise[9] :
		(tsel_q[1:0] == 2'h1) ? rise[10] :
		(tsel_q[1:0] == 2'h2) ? rise[11] : sw_sync;

	// multispeed locked to slow oscillator ticks
	trim_engine #(.CW(16), .TARGET(MS_TRIM_TARGET)) u_ms_trim (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.auto_i(osc_q.auto_trim_en & rdy[RDY_EXT_SLOW]),
		.sync_i(rise[10]),
		.tick_i(rise[13]),
		.load_i(trim_wr & wb_sel_i[0]),
		.load_val_i(wb_dat_i[7:0]),
		.trim_o(multispeed_trim_o)
	);

	// 48 MHz RC auto trim with manual load
	trim_engine #(.CW(16), .TARGET(T48_TRIM_TARGET)) u_48_trim (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.auto_i(tsel_q[2]),
		.sync_i(sync48),
		.tick_i(rise[14]),
		.load_i(trim_wr & wb_sel_i[1]),
		.load_val_i(wb_dat_i[15:8]),
		.trim_o(int_48m_trim_o)
	);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
			ffail_q <= 1'b0;
			sfail_q <= 1'b0;
			rflag_q <= 1'b0;
			sync_prev_q <= '0;
			div_q <= 7'h00;
			tick_pr_q <= 1'b0;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (req & ~ack_q)
				rdat_q <= rd_word;
			sync_prev_q <= sync_lv;
			// a new failure wins over a clear
			ffail_q <= fast_fail_ev | (ffail_q & ~clr_fast);
			sfail_q <= slow_fail_ev | (sfail_q & ~clr_slow);
			rflag_q <= clr_rflag;
			// divide slow RC ticks by 128
			if (rise[12])
				div_q <= div_q + 7'h01;
			tick_pr_q <= rise[12] & (div_q == SLOW_DIV_LAST);
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign osc_ctrl_o = osc_q;
	assign clk_cfg_o = cfg_q;
	assign sys_root_sel_o = act_q;
	assign sys_root_gate_o = st_q != SW_GATE;
	assign pll_ctrl_o = pll_q;
	assign kernel_sel_o = ksel_q;
	assign core_clk_en_o = gate_q[17];
	assign mem_clk_en_o = gate_q[16];
	assign periph_clk_en_o = gate_q[PERIPHS-1:0];
	// type-C clock only while the 16 MHz RC is enabled and ready
	assign typec_pd_clk_en_o = gate_q[PD_PERIPH] & osc_q.int_16m_en & rdy[RDY_INT_16M];
	assign general_clock_out_sel_o = cfg_q.gen_out_sel;
	assign slow_clock_out_en_o = cfg_q.slow_out_en;
	assign slow_clock_out_sel_o = cfg_q.slow_out_sel;
	assign slow_250hz_tick_o = tick_pr_q;
	assign fast_fail_irq_o = ffail_q;
	assign slow_fail_irq_o = sfail_q;
	assign reset_flag_clear_o = rflag_q;

	chk_fail_forces_16m: assert property (@(posedge clk_i) disable iff (rst_i)
		fast_fail_ev |=> act_q == SRC_INT_16M && ffail_q && osc_q.int_16m_en)
		else $error("failover did not select 16 MHz RC");
	chk_switch_needs_ready: assert property (@(posedge clk_i) disable iff (rst_i)
		(act_q != $past(act_q)) && !$past(fast_fail_ev) |-> $past(tgt_rdy, 2))
		else $error("root changed without ready source");
	chk_gate_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		!sys_root_gate_o |=> sys_root_gate_o && act_q == $past(cfg_q.sys_sel))
		else $error("gate window wrong");
	chk_reset_root: assert property (@(posedge clk_i)
		$past(rst_i) |-> act_q == SRC_MULTISPEED && osc_q.multispeed_range == MS_RANGE_4M)
		else $error("reset root not 4 MHz multispeed");
	chk_range_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_q.multispeed_range <= MS_RANGE_MAX)
		else $error("multispeed range out of span");
	chk_prescale_span: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_q.ahb_div <= AHB_DIV_MAX && cfg_q.apb_hs_div <= APB_DIV_MAX
		&& cfg_q.apb_ls_div <= APB_DIV_MAX)
		else $error("prescaler code out of span");
	chk_slow_fail_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		sfail_q && !clr_slow |=> sfail_q)
		else $error("slow failure flag lost");
	chk_ns_read_blank: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !ack_q && blocked |=> wb_ack_o && wb_dat_o == 32'h00000000)
		else $error("secured register leaked");
	chk_typec_needs_rc: assert property (@(posedge clk_i) disable iff (rst_i)
		typec_pd_clk_en_o |-> rdy[RDY_INT_16M])
		else $error("type-C clock without 16 MHz RC");
	chk_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer timing");
	cov_switch_pll: cover property (@(posedge clk_i) disable iff (rst_i)
		st_q == SW_GATE && cfg_q.sys_sel == SRC_PLL);
	cov_failover: cover property (@(posedge clk_i) disable iff (rst_i) fast_fail_ev);
	cov_slow_tick: cover property (@(posedge clk_i) disable iff (rst_i) slow_250hz_tick_o);
endmodule // system_clock_controller

// ===== verification/osc_model.sv
// Stand-in for the oscillators and the PLL around the clock controller.
// Assumes the bench commands slow start-up and oscillator failures.
`timescale 1ns/100ps
module osc_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Controls from the controller and the bench
	input wire clock_ctrl_pkg::osc_ctrl_type osc_ctrl_i,
	input wire logic pll_en_i,
	input wire logic slow_i,
	input wire logic kill_fast_i,
	input wire logic kill_slow_i,
	// Status and tick levels
	output logic [6:0] ready_o,
	output logic fast_fail_o,
	output logic slow_fail_o,
	output logic int_slow_tick_o,
	output logic ext_slow_tick_o,
	output logic multispeed_tick_o,
	output logic int_48m_tick_o
);
	import clock_ctrl_pkg::*;
	logic [6:0] en;
	logic [5:0] wait_q;
	logic [7:0] cnt_q;
	assign en = {osc_ctrl_i.int_48m_en, osc_ctrl_i.int_slow_en,
		osc_ctrl_i.ext_slow_en & ~kill_slow_i, pll_en_i, osc_ctrl_i.multispeed_en,
		osc_ctrl_i.int_16m_en, osc_ctrl_i.ext_fast_en & ~kill_fast_i};
	// a failure is a rising level
	assign fast_fail_o = kill_fast_i;
	assign slow_fail_o = kill_slow_i;
	// Ticks stand still while the source is not ready; each level lasts 4+ clocks
	assign int_slow_tick_o = cnt_q[2] & ready_o[RDY_INT_SLOW];
	assign ext_slow_tick_o = cnt_q[4] & ready_o[RDY_EXT_SLOW];
	assign multispeed_tick_o = cnt_q[3] & ready_o[RDY_MULTI];
	assign int_48m_tick_o = cnt_q[2] & ready_o[RDY_INT_48M];
	always_ff @(posedge clk_i)
	begin
		cnt_q <= cnt_q + 8'h01;
		if (rst_i)
		begin
			cnt_q <= 8'h00;
			wait_q <= 6'h00;
			ready_o <= 7'h00;
		end
		else if (en == ready_o)
			wait_q <= 6'h00;
		else if (wait_q >= (slow_i ? 6'h28 : 6'h02))
		begin
			ready_o <= en;
			wait_q <= 6'h00;
		end
		else
			wait_q <= wait_q + 6'h01;
	end
endmodule // osc_model

// ===== verification/system_clock_controller_tb.sv
// Self-checking bench of the clock controller over classic Wishbone.
// Assumes osc_model stands for the oscillators and PLL.
`timescale 1ns/100ps
module system_clock_controller_tb;
	import clock_ctrl_pkg::*;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_secure_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, bsel;
	logic [31:0] wb_dat_i, wb_dat_o, rd, v, cfg;
	logic sec_opt, usb_sof_i, trim_sync_i, slow_i, kill_fast_i, kill_slow_i, pll_en;
	logic [6:0] ready;
	logic ffail, sfail, t_islow, t_eslow, t_ms, t_48m;
	osc_ctrl_type osc_ctrl_o;
	clk_cfg_type clk_cfg_o;
	logic [1:0] root;
	logic core_en, mem_en, typec_en, slow_clock_out_en, slow_clock_out_sel, tick250, firq, sirq, rflag;
	logic [11:0] pll_ctrl_o;
	logic [7:0] ms_trim, t48_trim, ksel;
	logic [15:0] periph_en;
	logic [2:0] mco_sel;
	logic [1:0] srcs [4];
	integer n_errors, checked, seed, i, n;

	system_clock_controller u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_secure_i(wb_secure_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .security_enable_option_i(sec_opt), .osc_ready_i(ready),
		.ext_fast_fail_i(ffail), .ext_slow_fail_i(sfail), .usb_sof_i(usb_sof_i),
		.ext_slow_tick_i(t_eslow), .trim_sync_input_i(trim_sync_i), .int_slow_tick_i(t_islow),
		.multispeed_tick_i(t_ms), .int_48m_tick_i(t_48m), .osc_ctrl_o(osc_ctrl_o),
		.clk_cfg_o(clk_cfg_o), .sys_root_sel_o(root), .sys_root_gate_o(),
		.pll_ctrl_o(pll_ctrl_o), .kernel_sel_o(ksel), .multispeed_trim_o(ms_trim),
		.int_48m_trim_o(t48_trim), .core_clk_en_o(core_en), .mem_clk_en_o(mem_en),
		.periph_clk_en_o(periph_en), .typec_pd_clk_en_o(typec_en),
		.general_clock_out_sel_o(mco_sel), .slow_clock_out_en_o(slow_clock_out_en),
		.slow_clock_out_sel_o(slow_clock_out_sel), .slow_250hz_tick_o(tick250),
		.fast_fail_irq_o(firq), .slow_fail_irq_o(sirq), .reset_flag_clear_o(rflag));
	assign pll_en = pll_ctrl_o[0];
	osc_model u_osc (.clk_i(clk_i), .rst_i(rst_i), .osc_ctrl_i(osc_ctrl_o), .pll_en_i(pll_en),
		.slow_i(slow_i), .kill_fast_i(kill_fast_i), .kill_slow_i(kill_slow_i),
		.ready_o(ready), .fast_fail_o(ffail), .slow_fail_o(sfail), .int_slow_tick_o(t_islow),
		.ext_slow_tick_o(t_eslow), .multispeed_tick_o(t_ms), .int_48m_tick_o(t_48m));

	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Trim sync sources keep each level for 8 clocks
	always @(posedge clk_i)
	begin
		usb_sof_i <= ~usb_sof_i;
		trim_sync_i <= usb_sof_i;
		repeat (7) @(posedge clk_i);
	end

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			n_errors = n_errors + 1;
		end
	end
	endtask

	// One classic cycle; holds until ack is sampled high
	task xfer(input logic we, input logic [7:0] a, input logic [31:0] d, input logic sec);
	integer k;
	begin
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= bsel;
		wb_secure_i <= sec;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k = k + 1;
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		chk("ack latency", 32'd2, k);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	end
	endtask

	task rd_chk(input string what, input logic [7:0] a, input logic sec, input logic [31:0] e);
	begin
		xfer(1'b0, a, 32'h0, sec);
		chk(what, e, rd);
	end
	endtask

	task wait_root(input logic [1:0] s);
	begin
		n = 0;
		while (root !== s && n < 100)
		begin
			@(negedge clk_i);
			n = n + 1;
		end
		chk("root", {30'h0, s}, {30'h0, root});
	end
	endtask

	task end_sim;
	begin
		$display("mismatches %0d comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	initial
	begin
		#200000;
		n_errors = n_errors + 1;
		end_sim;
	end

	initial
	begin
		seed = 32'ha800;
		n_errors = 0;
		checked = 0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_secure_i, sec_opt, usb_sof_i, trim_sync_i} = 7'h00;
		{kill_fast_i, kill_slow_i} = 2'h0;
		slow_i = 1'b1;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		bsel = 4'hf;
		wb_sel_i = 4'hf;
		rst_i = 1'b1;
		srcs = '{SRC_PLL, SRC_INT_16M, SRC_MULTISPEED, SRC_EXT_FAST};
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("osc_ctrl", OFS_OSC_CTRL, 1'b1, {15'h0, OSC_CTRL_RST});
		chk("reset root", {30'h0, SRC_MULTISPEED}, {30'h0, root});
		rd_chk("gate", OFS_GATE, 1'b1, {14'h0, GATE_RST});
		rd_chk("unmapped", 8'h40, 1'b1, 32'h0);
		$display("test reset done");
		// Target not yet ready: root must hold
		xfer(1'b1, OFS_CLK_CFG, {30'h0, SRC_EXT_FAST}, 1'b1);
		repeat (30) @(negedge clk_i);
		chk("root held", {30'h0, SRC_MULTISPEED}, {30'h0, root});
		xfer(1'b1, OFS_OSC_CTRL, 32'h106f, 1'b1);
		wait_root(SRC_EXT_FAST);
		slow_i <= 1'b0;
		xfer(1'b1, OFS_PLL, 32'h1, 1'b1);
		for (i = 0; i < 4; i = i + 1)
		begin
			v = $random(seed);
			cfg = {14'h0, v[17], v[16:12], 1'b0, v[10:9], 1'b0, v[7:6], 1'b0, v[4:2], srcs[i]};
			xfer(1'b1, OFS_CLK_CFG, cfg, 1'b1);
			wait_root(srcs[i]);
			rd_chk("clk_cfg", OFS_CLK_CFG, 1'b1, cfg | {10'h0, srcs[i], 20'h0});
			chk("out sel", {27'h0, v[16:12]}, {27'h0, slow_clock_out_en, slow_clock_out_sel, mco_sel});
		end
		xfer(1'b1, OFS_CLK_CFG, 32'h0ffe, 1'b1);
		rd_chk("clamp", OFS_CLK_CFG, 1'b1, 32'h00200922);
		$display("test root switch done");
		xfer(1'b1, OFS_OSC_CTRL, 32'h516f, 1'b1);
		kill_fast_i <= 1'b1;
		for (n = 0; n < 50 && firq !== 1'b1; n = n + 1)
			@(negedge clk_i);
		chk("fast irq", 32'h1, {31'h0, firq});
		chk("failover", {30'h0, SRC_INT_16M}, {30'h0, root});
		xfer(1'b1, OFS_FLAG_CLR, 32'h1, 1'b1);
		@(negedge clk_i);
		chk("fast clr", 32'h0, {31'h0, firq});
		kill_slow_i <= 1'b1;
		repeat (20) @(negedge clk_i);
		chk("slow off", 32'h0, {31'h0, sirq});
		@(posedge clk_i);
		kill_slow_i <= 1'b0;
		xfer(1'b1, OFS_OSC_CTRL, 32'hd16f, 1'b1);
		repeat (10) @(posedge clk_i);
		kill_slow_i <= 1'b1;
		for (n = 0; n < 50 && sirq !== 1'b1; n = n + 1)
			@(negedge clk_i);
		chk("slow irq", 32'h1, {31'h0, sirq});
		xfer(1'b1, OFS_FLAG_CLR, 32'h2, 1'b1);
		@(negedge clk_i);
		chk("slow clr", 32'h0, {31'h0, sirq});
		xfer(1'b1, OFS_FLAG_CLR, 32'h4, 1'b1);
		@(negedge clk_i);
		chk("clear pulse", 32'h1, {31'h0, rflag});
		@(negedge clk_i);
		chk("clear pulse end", 32'h0, {31'h0, rflag});
		$display("test failure done");
		n = 0;
		repeat (2048)
		begin
			@(negedge clk_i);
			if (tick250 === 1'b1)
				n = n + 1;
		end
		chk("250 Hz ticks", 32'd2, n);
		$display("test slow divider done");
		for (i = 0; i < 4; i = i + 1)
		begin
			v = $random(seed);
			v[0] = (i != 1);
			xfer(1'b1, OFS_GATE, v, 1'b1);
			@(negedge clk_i);
			chk("gates", {14'h0, v[17:0]}, {14'h0, core_en, mem_en, periph_en});
			chk("typec", {31'h0, v[0]}, {31'h0, typec_en});
		end
		bsel = 4'h1;
		xfer(1'b1, OFS_GATE, 32'h0, 1'b1);
		bsel = 4'hf;
		rd_chk("gate lane", OFS_GATE, 1'b1, {14'h0, v[17:8], 8'h00});
		v = $random(seed);
		xfer(1'b1, OFS_TRIM, {14'h0, v[17:0]}, 1'b1);
		@(negedge clk_i);
		chk("trims", {16'h0, v[15:0]}, {16'h0, t48_trim, ms_trim});
		xfer(1'b1, OFS_KSEL, v, 1'b1);
		rd_chk("ksel", OFS_KSEL, 1'b1, {24'h0, v[7:0]});
		chk("ksel out", {24'h0, v[7:0]}, {24'h0, ksel});
		xfer(1'b1, OFS_PLL, v | 32'h1, 1'b1);
		rd_chk("pll", OFS_PLL, 1'b1, {20'h0, v[11:1], 1'b1});
		$display("test gating done");
		xfer(1'b1, OFS_SEC, 32'h1, 1'b1);
		xfer(1'b1, OFS_GATE, 32'h30001, 1'b1);
		sec_opt <= 1'b1;
		rd_chk("ns osc", OFS_OSC_CTRL, 1'b0, 32'h0);
		xfer(1'b1, OFS_OSC_CTRL, 32'h0, 1'b0);
		rd_chk("s osc", OFS_OSC_CTRL, 1'b1, 32'hd16f);
		rd_chk("ns gate", OFS_GATE, 1'b0, 32'h30000);
		xfer(1'b1, OFS_GATE, 32'h0, 1'b0);
		@(negedge clk_i);
		chk("ns gate wr", 32'h1, {14'h0, core_en, mem_en, periph_en});
		@(posedge clk_i);
		sec_opt <= 1'b0;
		$display("test security done");
		for (i = 0; i < 16; i = i + 1)
		begin
			xfer(1'b1, OFS_OSC_CTRL, 32'hd10f | (i << 4), 1'b1);
			rd_chk("range", OFS_OSC_CTRL, 1'b1, 32'hd10f | ((i > 11 ? 11 : i) << 4));
		end
		// No 48 MHz ticks run, so the second software sync, once auto mode is on, steps the trim up
		bsel = 4'h2;
		xfer(1'b1, OFS_TRIM, 32'h00004000, 1'b1);
		bsel = 4'h4;
		xfer(1'b1, OFS_TRIM, 32'h000f0000, 1'b1);
		xfer(1'b1, OFS_TRIM, 32'h000f0000, 1'b1);
		bsel = 4'hf;
		@(negedge clk_i);
		chk("48M auto trim", 32'h41, {24'h0, t48_trim});
		$display("test ranges done");
		end_sim;
	end
endmodule // system_clock_controller_tb
